/* logic/hpf_pkg.sv */
/*
 * Constants, register map and carrier types for the host port pin-function
 * block. Assumes a 32-bit classic Wishbone slave port and a 13-pin host port.
 */
package hpf_pkg;

    // ************************************************************
    // Sizes
    // ************************************************************
    localparam int unsigned HPF_PINS = 13;
    localparam int unsigned HPF_DW = 8;
    localparam int unsigned HPF_AW = 10;
    localparam int unsigned HPF_FIFO_DEPTH = 32;
    localparam int unsigned HPF_CW = 6;

    // ************************************************************
    // Register byte offsets
    // ************************************************************
    localparam logic [7:0] HPF_OFS_CTRL = 8'h00;
    localparam logic [7:0] HPF_OFS_DIR = 8'h04;
    localparam logic [7:0] HPF_OFS_GOUT = 8'h08;
    localparam logic [7:0] HPF_OFS_POL = 8'h0c;
    localparam logic [7:0] HPF_OFS_GIN = 8'h10;
    localparam logic [7:0] HPF_OFS_RXDATA = 8'h14;
    localparam logic [7:0] HPF_OFS_TXDATA = 8'h18;
    localparam logic [7:0] HPF_OFS_STAT = 8'h1c;

    // ************************************************************
    // Pin positions and status bits
    // ************************************************************
    localparam int unsigned HPF_PIN_A0 = 8;
    localparam int unsigned HPF_PIN_A2 = 10;
    localparam int unsigned HPF_PIN_RW = 11;
    localparam int unsigned HPF_PIN_DS = 12;
    localparam int unsigned HPF_ST_EMPTY = 0;
    localparam int unsigned HPF_ST_FULL = 1;
    localparam int unsigned HPF_ST_OVF = 2;
    localparam int unsigned HPF_ST_TAKEN = 3;
    localparam int unsigned HPF_ST_CNT = 8;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [HPF_CW-1:0] HPF_CTRL_RST = 6'h00;
    localparam logic [HPF_PINS-1:0] HPF_PIN_RST = 13'h0000;
    localparam logic [HPF_DW-1:0] HPF_TX_RST = 8'h00;

    // Polarity bits: 1 means the strobe is active high
    typedef struct packed {
        logic ds_high;
        logic rs_high;
        logic as_high;
        logic dual;
        logic mux;
        logic host_fn;
    } hpf_ctrl_t;

    typedef struct packed {
        logic [HPF_AW-1:0] addr;
        logic [HPF_DW-1:0] data;
    } hpf_word_t;

endpackage : hpf_pkg

/* logic/hpf_port.sv */
/*
 * Host port pin-function select with its write FIFO and Wishbone slave.
 * Assumes pad inputs already synchronous to clk_i; the pad wire is resolved
 * outside from pad_o and pad_oe_o.
 */
`timescale 1ns/1ps

module hpf_fifo #(
    parameter int unsigned WIDTH = 18,
    parameter int unsigned DEPTH = 32
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic in_valid_i,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic in_ready_o,
    output logic out_valid_o,
    output logic [WIDTH-1:0] out_data_o,
    input wire logic out_ready_i,
    output logic [$clog2(DEPTH):0] count_o
);
    localparam int unsigned PW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0] wp_q;
    logic [PW-1:0] rp_q;
    logic [PW:0] cnt_q;
    logic push;
    logic pop;

    assign in_ready_o = (cnt_q != (PW+1)'(DEPTH));
    assign out_valid_o = (cnt_q != '0);
    assign out_data_o = mem[rp_q];
    assign count_o = cnt_q;
    assign push = in_valid_i & in_ready_o;
    assign pop = out_valid_o & out_ready_i;

    always_ff @(posedge clk_i)
    begin
        if (push)
            mem[wp_q] <= in_data_i;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
        end
        else
        begin
            if (push)
                wp_q <= wp_q + 1'b1;
            if (pop)
                rp_q <= rp_q + 1'b1;
            cnt_q <= cnt_q + (PW+1)'(push) - (PW+1)'(pop);
        end
    end
endmodule : hpf_fifo

module hpf_port (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [hpf_pkg::HPF_PINS-1:0] pad_i,
    output logic [hpf_pkg::HPF_PINS-1:0] pad_o,
    output logic [hpf_pkg::HPF_PINS-1:0] pad_oe_o
);
    import hpf_pkg::*;

    // ************************************************************
    // Register bus
    // ************************************************************
    function automatic logic [15:0] hpf_bwr(input logic [15:0] old, input logic [31:0] d,
                                            input logic [3:0] sel);
        hpf_bwr = old;
        if (sel[0])
            hpf_bwr[7:0] = d[7:0];
        if (sel[1])
            hpf_bwr[15:8] = d[15:8];
    endfunction : hpf_bwr

    hpf_ctrl_t ctrl_q;
    logic [HPF_PINS-1:0] dir_q;
    logic [HPF_PINS-1:0] gout_q;
    logic [HPF_PINS-1:0] pol_q;
    logic [HPF_PINS-1:0] gin_q;
    logic [HPF_DW-1:0] tx_q;
    logic ovf_q;
    logic taken_q;
    logic ack_q;
    logic [31:0] rdat_q;
    logic req;
    logic wr_en;
    logic rd_en;
    hpf_word_t head;
    logic head_valid;
    logic fifo_ready;
    logic [5:0] fifo_cnt;

    assign req = wb_cyc_i & wb_stb_i & ~ack_q;
    assign wr_en = req & wb_we_i;
    assign rd_en = req & ~wb_we_i;
    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdat_q;

    // Ack is registered, so every access costs exactly one wait state
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            ack_q <= 1'b0;
        else
            ack_q <= req;
    end

    a_wb_ack: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_cyc_i & wb_stb_i & !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
        else $error("bus ack not one cycle");

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ctrl_q <= hpf_ctrl_t'(HPF_CTRL_RST);
            dir_q <= HPF_PIN_RST;
            gout_q <= HPF_PIN_RST;
            pol_q <= HPF_PIN_RST;
            tx_q <= HPF_TX_RST;
        end
        else if (wr_en)
        begin
            case (wb_adr_i)
                HPF_OFS_CTRL: ctrl_q <= hpf_ctrl_t'(HPF_CW'(hpf_bwr({10'h000, ctrl_q}, wb_dat_i, wb_sel_i)));
                HPF_OFS_DIR: dir_q <= 13'(hpf_bwr({3'h0, dir_q}, wb_dat_i, wb_sel_i));
                HPF_OFS_GOUT: gout_q <= 13'(hpf_bwr({3'h0, gout_q}, wb_dat_i, wb_sel_i));
                HPF_OFS_POL: pol_q <= 13'(hpf_bwr({3'h0, pol_q}, wb_dat_i, wb_sel_i));
                HPF_OFS_TXDATA: tx_q <= 8'(hpf_bwr({8'h00, tx_q}, wb_dat_i, wb_sel_i));
                default: ;
            endcase
        end
    end

    // Unmapped reads return zero; a read of the receive word pops it
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            rdat_q <= 32'h0000_0000;
        end
        else if (rd_en)
        begin
            case (wb_adr_i)
                HPF_OFS_CTRL: rdat_q <= {26'h0, ctrl_q};
                HPF_OFS_DIR: rdat_q <= {19'h0, dir_q};
                HPF_OFS_GOUT: rdat_q <= {19'h0, gout_q};
                HPF_OFS_POL: rdat_q <= {19'h0, pol_q};
                HPF_OFS_GIN: rdat_q <= {19'h0, gin_q};
                HPF_OFS_RXDATA: rdat_q <= head_valid ? {14'h0, head} : 32'h0000_0000;
                HPF_OFS_TXDATA: rdat_q <= {24'h0, tx_q};
                HPF_OFS_STAT: rdat_q <= {18'h0, fifo_cnt, 4'h0, taken_q, ovf_q, ~fifo_ready, ~head_valid};
                default: rdat_q <= 32'h0000_0000;
            endcase
        end
    end

    // ************************************************************
    // Host strobe decode
    // ************************************************************
    logic as_act;
    logic rs_act;
    logic ds_act;
    logic rd_act;
    logic wr_act;
    logic wr_prev_q;
    logic rd_prev_q;
    logic [HPF_AW-1:0] addr_q;
    logic [HPF_DW-1:0] wdat_q;
    logic push;
    logic wr_end;
    logic rd_end;

    // Strobes obey the programmed polarity; the host must match it
    assign as_act = ~(pad_i[HPF_PIN_A0] ^ ctrl_q.as_high);
    assign rs_act = ~(pad_i[HPF_PIN_RW] ^ ctrl_q.rs_high);
    assign ds_act = ~(pad_i[HPF_PIN_DS] ^ ctrl_q.ds_high);
    assign rd_act = ctrl_q.host_fn & (ctrl_q.dual ? rs_act : ds_act & pad_i[HPF_PIN_RW]);
    assign wr_act = ctrl_q.host_fn & (ctrl_q.dual ? ds_act : ds_act & ~pad_i[HPF_PIN_RW]);
    assign wr_end = wr_prev_q & ~wr_act;
    assign rd_end = rd_prev_q & ~rd_act;
    assign push = wr_end & fifo_ready;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wr_prev_q <= 1'b0;
            rd_prev_q <= 1'b0;
        end
        else
        begin
            wr_prev_q <= wr_act;
            rd_prev_q <= rd_act;
        end
    end

    // Multiplexed address follows the bus while the strobe is active and
    // holds after it; non-multiplexed address is caught during the write
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            addr_q <= '0;
        end
        else if (ctrl_q.host_fn & ctrl_q.mux & as_act)
        begin
            addr_q <= {pad_i[HPF_PIN_A2:HPF_PIN_A0+1], pad_i[HPF_DW-1:0]};
        end
        else if (ctrl_q.host_fn & ~ctrl_q.mux & wr_act)
        begin
            addr_q <= {7'h00, pad_i[HPF_PIN_A2:HPF_PIN_A0]};
        end
    end

    a_mux_addr: assert property (@(posedge clk_i) disable iff (rst_i)
        ctrl_q.host_fn & ctrl_q.mux & as_act
        |=> addr_q == {$past(pad_i[HPF_PIN_A2:HPF_PIN_A0+1]), $past(pad_i[HPF_DW-1:0])})
        else $error("multiplexed address not latched");
    a_plain_addr: assert property (@(posedge clk_i) disable iff (rst_i)
        ctrl_q.host_fn & !ctrl_q.mux & wr_act |=> addr_q[2:0] == $past(pad_i[HPF_PIN_A2:HPF_PIN_A0]))
        else $error("non-multiplexed address wrong");

    // Data is sampled through the strobe so the word survives its release
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            wdat_q <= '0;
        else if (wr_act)
            wdat_q <= pad_i[HPF_DW-1:0];
    end

    // A full FIFO cannot stall the host, so the word is dropped and flagged;
    // a new event beats a clear in the same cycle
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ovf_q <= 1'b0;
            taken_q <= 1'b0;
        end
        else
        begin
            ovf_q <= (wr_end & ~fifo_ready) |
                     (ovf_q & ~(wr_en & wb_adr_i == HPF_OFS_STAT & wb_sel_i[0] & wb_dat_i[HPF_ST_OVF]));
            taken_q <= rd_end |
                       (taken_q & ~(wr_en & wb_adr_i == HPF_OFS_STAT & wb_sel_i[0] & wb_dat_i[HPF_ST_TAKEN]));
        end
    end

    hpf_fifo #(
        .WIDTH(HPF_AW + HPF_DW),
        .DEPTH(HPF_FIFO_DEPTH)
    ) u_fifo (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .in_valid_i(push),
        .in_data_i({addr_q, wdat_q}),
        .in_ready_o(fifo_ready),
        .out_valid_o(head_valid),
        .out_data_o(head),
        .out_ready_i(rd_en & (wb_adr_i == HPF_OFS_RXDATA)),
        .count_o(fifo_cnt)
    );

    a_write_push: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_end & fifo_ready & !(rd_en & wb_adr_i == HPF_OFS_RXDATA & head_valid)
        |=> fifo_cnt == $past(fifo_cnt) + 6'h01)
        else $error("host write not queued");

    // ************************************************************
    // Pad drivers
    // ************************************************************
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            gin_q <= HPF_PIN_RST;
        else
            gin_q <= pad_i ^ pol_q;
    end

    for (genvar g = 0; g < HPF_PINS; g++)
    begin : g_pad
        always_ff @(posedge clk_i)
        begin
            if (rst_i)
            begin
                pad_oe_o[g] <= 1'b0;
                pad_o[g] <= 1'b0;
            end
            else if (!ctrl_q.host_fn)
            begin
                pad_oe_o[g] <= dir_q[g];
                pad_o[g] <= gout_q[g] ^ pol_q[g];
            end
            else if (g < HPF_DW)
            begin
                pad_oe_o[g] <= rd_act;
                pad_o[g] <= tx_q[g % HPF_DW];
            end
            else
            begin
                // Address and strobe pins stay inputs in host mode
                pad_oe_o[g] <= 1'b0;
                pad_o[g] <= 1'b0;
            end
        end
    end

    a_reset_hiz: assert property (@(posedge clk_i) $past(rst_i) |-> pad_oe_o == '0)
        else $error("pad enabled after reset");
    a_gpio_dir: assert property (@(posedge clk_i) disable iff (rst_i)
        !ctrl_q.host_fn ##1 !ctrl_q.host_fn |-> pad_oe_o == $past(dir_q))
        else $error("gpio direction mismatch");
    a_gpio_pol: assert property (@(posedge clk_i) disable iff (rst_i)
        !ctrl_q.host_fn ##1 !ctrl_q.host_fn |-> pad_o == ($past(gout_q) ^ $past(pol_q)))
        else $error("gpio output polarity wrong");
    a_host_inputs: assert property (@(posedge clk_i) disable iff (rst_i)
        ctrl_q.host_fn |=> pad_oe_o[HPF_PINS-1:HPF_DW] == '0)
        else $error("address pin driven in host mode");
    a_single_read: assert property (@(posedge clk_i) disable iff (rst_i)
        ctrl_q.host_fn & !ctrl_q.dual & ds_act & pad_i[HPF_PIN_RW] |=> pad_oe_o[HPF_DW-1:0] == 8'hff)
        else $error("single strobe read not driven");
    a_dual_read: assert property (@(posedge clk_i) disable iff (rst_i)
        ctrl_q.host_fn & ctrl_q.dual & rs_act & !ds_act ##1 ctrl_q.host_fn
        |-> pad_oe_o[0] && !wr_prev_q)
        else $error("double strobe read wrong");

    c_host_write: cover property (@(posedge clk_i) disable iff (rst_i) push);
    c_fifo_full: cover property (@(posedge clk_i) disable iff (rst_i) !fifo_ready);
    c_mux_read: cover property (@(posedge clk_i) disable iff (rst_i) ctrl_q.mux & rd_end);
    c_gpio_out: cover property (@(posedge clk_i) disable iff (rst_i) !ctrl_q.host_fn & pad_oe_o[0]);

endmodule : hpf_port

/* tb/hpf_host_model.sv */
/*
 * Behavioural host processor standing on the far side of the host port pins.
 * Assumes the bench calls one task at a time and that the device wins any
 * contention on a pin whose output enable is high.
 */
`timescale 1ns/1ps

module hpf_host_model (
    input wire logic clk_i,
    input wire logic [hpf_pkg::HPF_PINS-1:0] pad_o,
    input wire logic [hpf_pkg::HPF_PINS-1:0] pad_oe_o,
    output logic [hpf_pkg::HPF_PINS-1:0] pad_i
);
    import hpf_pkg::*;

    // ************************************************************
    // Pin drive
    // ************************************************************
    logic [12:0] drv_q = 13'h0000;
    logic [12:0] own_q = 13'h1fff;
    logic [12:0] tog_q = 13'h0aaa;

    // Released lines toggle so that a missing device drive never looks valid
    always @(posedge clk_i)
    begin
        tog_q <= ~tog_q;
    end

    assign pad_i = (pad_oe_o & pad_o) | (~pad_oe_o & ((own_q & drv_q) | (~own_q & tog_q)));

    function automatic logic [12:0] idle_v(input hpf_ctrl_t c);
        idle_v = 13'h0000;
        idle_v[12] = ~c.ds_high;
        idle_v[11] = c.dual ? ~c.rs_high : 1'b0;
        idle_v[8] = c.mux ? ~c.as_high : 1'b0;
    endfunction : idle_v

    task automatic drive(input logic [12:0] v, input logic [12:0] own);
        @(posedge clk_i);
        drv_q <= v;
        own_q <= own;
    endtask : drive

    task automatic idle(input hpf_ctrl_t c);
        drive(idle_v(c), 13'h1fff);
    endtask : idle

    task automatic host_write(input hpf_ctrl_t c, input logic [9:0] a, input logic [7:0] d);
        logic [12:0] v;
        v = idle_v(c);
        if (c.mux)
        begin
            v[10:9] = a[9:8];
            v[7:0] = a[7:0];
            v[8] = c.as_high;
            drive(v, 13'h1fff);
            v[8] = ~c.as_high;
        end
        else
            v[10:8] = a[2:0];
        v[7:0] = d;
        v[12] = c.ds_high;
        repeat (2) drive(v, 13'h1fff);
        v[12] = ~c.ds_high;
        repeat (2) drive(v, 13'h1fff);
    endtask : host_write

    task automatic host_read(input hpf_ctrl_t c, output logic [7:0] d);
        logic [12:0] v;
        v = idle_v(c);
        if (c.dual)
            v[11] = c.rs_high;
        else
        begin
            v[11] = 1'b1;
            v[12] = c.ds_high;
        end
        drive(v, 13'h1f00);
        repeat (3) @(posedge clk_i);
        d = pad_i[7:0];
        drive(idle_v(c), 13'h1f00);
        repeat (2) @(posedge clk_i);
        drive(idle_v(c), 13'h1fff);
    endtask : host_read
endmodule : hpf_host_model

/* tb/tb.sv */
/*
 * Self-checking bench for the host port pin-function block.
 * Assumes the host model answers on the pins and Wishbone reaches registers.
 */
`timescale 1ns/1ps

module tb;
    import hpf_pkg::*;

    // ************************************************************
    // Harness
    // ************************************************************
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic [12:0] pad_i;
    logic [12:0] pad_o;
    logic [12:0] pad_oe_o;
    int num_errors = 0;
    int tests_run = 0;
    int cyc_cnt = 0;
    int rst_cnt = 0;
    logic [31:0] seed_q = 32'd34;
    hpf_ctrl_t ctrl_q = '0;

    always #12.5 clk_i = ~clk_i;

    hpf_port u_hpf_port (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pad_i(pad_i), .pad_o(pad_o), .pad_oe_o(pad_oe_o));
    hpf_host_model u_hpf_host_model (.clk_i(clk_i), .pad_o(pad_o), .pad_oe_o(pad_oe_o), .pad_i(pad_i));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic give_verdict();
        if (num_errors == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : give_verdict

    function automatic logic [31:0] rnd();
        seed_q ^= seed_q << 13;
        seed_q ^= seed_q >> 17;
        seed_q ^= seed_q << 5;
        return seed_q;
    endfunction : rnd

    function automatic logic [31:0] exp_word(input logic mux, input logic [9:0] a, input logic [7:0] d);
        return {14'h0, (mux ? a : {7'h00, a[2:0]}), d};
    endfunction : exp_word

    // Pins stay released under reset; pins 8-12 are never driven in host mode
    always @(posedge clk_i)
    begin
        cyc_cnt++;
        rst_cnt = rst_i ? rst_cnt + 1 : 0;
        if (rst_cnt >= 2)
            check(32'(pad_oe_o), 32'h0);
        else if (!rst_i && ctrl_q.host_fn)
            check(32'(pad_oe_o[12:8]), 32'h0);
        if (cyc_cnt > 30000)
        begin
            num_errors++;
            give_verdict();
        end
    end

    task automatic wb(input logic [7:0] adr, input logic we, input logic [31:0] wd, output logic [31:0] rd);
        int n = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= wd;
        wb_sel_i <= 4'hf;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (wb_ack_o !== 1'b1 && n < 50);
        if (n >= 50)
            num_errors++;
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask : wb

    task automatic wr(input logic [7:0] adr, input logic [31:0] wd);
        logic [31:0] dummy;
        wb(adr, 1'b1, wd, dummy);
    endtask : wr

    task automatic do_reset();
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        ctrl_q = '0;
    endtask : do_reset

    // ************************************************************
    // Scenarios
    // ************************************************************
    initial
    begin
        logic [31:0] r, dir, gout, pol, drv, s;
        logic [7:0] got;
        logic [31:0] exp_q [33];
        hpf_ctrl_t c;
        do_reset();
        for (int i = 0; i < 8; i++)
        begin
            dir = rnd() & 32'h1fff;
            gout = rnd() & 32'h1fff;
            pol = (i == 7) ? 32'h1fff : rnd() & 32'h1fff;
            drv = rnd() & 32'h1fff;
            if (i == 7)
                dir = 32'h1fff;
            u_hpf_host_model.drive(drv[12:0], 13'h1fff);
            wr(HPF_OFS_DIR, dir);
            wr(HPF_OFS_GOUT, gout);
            wr(HPF_OFS_POL, pol);
            repeat (2) @(posedge clk_i);
            check(32'(pad_oe_o), dir);
            check(32'(pad_o) & dir, (gout ^ pol) & dir);
            wb(HPF_OFS_GIN, 1'b0, 32'h0, s);
            check(s, (((gout ^ pol) & dir) | (drv & ~dir)) ^ pol);
        end
        do_reset();
        for (int m = 0; m < 32; m++)
        begin
            c = hpf_ctrl_t'({m[4:0], 1'b1});
            r = rnd();
            wr(HPF_OFS_CTRL, 32'h0);
            ctrl_q = '0;
            u_hpf_host_model.idle(c);
            wr(HPF_OFS_CTRL, 32'(c));
            ctrl_q = c;
            u_hpf_host_model.host_write(c, r[9:0], r[17:10]);
            wb(HPF_OFS_RXDATA, 1'b0, 32'h0, s);
            check(s, exp_word(c.mux, r[9:0], r[17:10]));
            wr(HPF_OFS_TXDATA, 32'(r[25:18]));
            u_hpf_host_model.host_read(c, got);
            check(32'(got), 32'(r[25:18]));
            wb(HPF_OFS_STAT, 1'b0, 32'h0, s);
            check(32'({s[13:8], s[3:0]}), 32'h009);
        end
        c = hpf_ctrl_t'(6'h01);
        // Park the pins for the new style while the port is still GPIO
        wr(HPF_OFS_CTRL, 32'h0);
        u_hpf_host_model.idle(c);
        wr(HPF_OFS_CTRL, 32'(c));
        ctrl_q = c;
        for (int k = 0; k < 33; k++)
        begin
            r = rnd();
            exp_q[k] = exp_word(1'b0, r[9:0], r[17:10]);
            u_hpf_host_model.host_write(c, r[9:0], r[17:10]);
        end
        wb(HPF_OFS_STAT, 1'b0, 32'h0, s);
        check({s[13:8], s[2:0]}, {6'h20, 3'h6});
        wr(HPF_OFS_STAT, 32'hc);
        for (int k = 0; k < 32; k++)
        begin
            wb(HPF_OFS_RXDATA, 1'b0, 32'h0, s);
            check(s, exp_q[k]);
        end
        wb(HPF_OFS_STAT, 1'b0, 32'h0, s);
        check(32'(s[3:0]), 32'h1);
        wb(HPF_OFS_RXDATA, 1'b0, 32'h0, s);
        check(s, 32'h0);
        wr(8'h40, 32'hffff);
        wb(8'h40, 1'b0, 32'h0, s);
        check(s, 32'h0);
        give_verdict();
    end
endmodule : tb
